// ==== rtl/flash_erase_sequencer.sv ====
/*
 * Erase, suspend and resume sequencer of a serial flash device: decodes
 * frames from the link, checks write enable and protection, times erases.
 * Assumes protection hit inputs are driven combinationally from
 * ERASE_ADDR_O and ERASE_KIND_O by the protection logic on CLOCK_I.
 */
// Functional notes
// - 20h plus address erases one 4K sector
// - 52h plus address erases one 32K block
// - D8h plus address erases one 64K block
// - C7h or 60h erases the whole array
// - Erase refused unless write enable latch set
// - Select must rise exactly on byte boundary
// - Self-timed erase holds busy, status stays readable
// - Erase completion clears the write enable latch
// - Protected sector or block is never erased
// - Array erase refused if anything protected
// - 75h pauses sector or block erase
// - Suspend ignored during whole array erase
// - Suspend taken only when unpaused and busy
// - Pause flag sets at once, busy drops later
// - Power loss clears the pause flag
// - Resume taken only when paused and idle
// - Resume clears flag, busy within 200ns
// - Resume ignored after power loss
`timescale 1ns/10ps
`default_nettype none
`include "flash_erase_cfg.svh"

module flash_erase_sequencer #(
    parameter int SECTOR_ERASE_CYC     = 20000,
    parameter int HALF_BLOCK_ERASE_CYC = 40000,
    parameter int BLOCK_ERASE_CYC      = 60000,
    parameter int WHOLE_ARRAY_ERASE_CYC = 400000
) (
    input  wire logic                   CLOCK_I,
    input  wire logic                   SYS_RST_I,
    input  wire logic                   SCLK_I,
    input  wire logic                   CS_N_I,
    input  wire logic                   MOSI_I,
    output logic                        MISO_O,
    output logic                        MISO_OE_O,
    input  wire logic                   BP_HIT_I,
    input  wire logic                   LOCK_HIT_I,
    input  wire logic                   BP_ANY_I,
    input  wire logic                   LOCK_ANY_I,
    output logic                        BUSY_O,
    output logic                        WRITE_ENABLE_LATCH_O,
    output logic                        PAUSED_STATE_FLAG_O,
    output flash_erase_pkg::erase_kind_t ERASE_KIND_O,
    output logic [23:0]                 ERASE_ADDR_O,
    output logic                        ERASE_START_O,
    output logic                        ERASE_DONE_O
);
    import flash_erase_pkg::*;

    localparam int SUSP_MAX = `SUSPEND_LAT_CYC;
    localparam int RES_MAX  = `RESUME_LAT_CYC;

    logic [5:0]  link_bits;
    logic [31:0] link_word;
    logic        cs_lvl;
    logic        cs_prev_q;
    logic        frame_end;
    logic [7:0]  op;
    logic        len_op;
    logic        len_addr;
    logic [7:0]  status_byte;

    seq_state_t  state_q,  state_d;
    erase_kind_t kind_q,   kind_d;
    logic [23:0] addr_q,   addr_d;
    logic [31:0] timer_q,  timer_d;
    logic [15:0] lat_q,    lat_d;
    logic        latch_q,  latch_d;
    logic        busy_q,   busy_d;
    logic        pause_q,  pause_d;
    logic        start_q,  start_d;
    logic        done_q,   done_d;

    // ------------------------------------------------------------------------
    // Link side and crossings
    // ------------------------------------------------------------------------
    // Status byte sent back on every status read, busy or not
    always_comb begin
        status_byte                 = 8'h00;
        status_byte[`STAT_BUSY_BIT] = busy_q;
        status_byte[`STAT_LATCH_BIT] = latch_q;
        status_byte[`STAT_PAUSE_BIT] = pause_q;
    end

    spi_link_shifter #(.CNT_W(6)) u_link (
        .sclk_i    (SCLK_I),
        .cs_n_i    (CS_N_I),
        .mosi_i    (MOSI_I),
        .status_i  (status_byte),
        .bits_o    (link_bits),
        .word_o    (link_word),
        .miso_o    (MISO_O),
        .miso_oe_o (MISO_OE_O)
    );

    level_sync3 #(.W(1), .INIT(`RST_CS_LEVEL)) u_cs_sync (
        .clk_i (CLOCK_I),
        .rst_i (SYS_RST_I),
        .d_i   (CS_N_I),
        .q_o   (cs_lvl)
    );

    // Count and word are frozen once select is high, since the serial clock
    // stops; by the time the filtered select rises they have long settled.
    always_comb begin
        frame_end = cs_lvl & ~cs_prev_q;
        len_op    = (link_bits == `FRAME_BITS_OP);
        len_addr  = (link_bits == `FRAME_BITS_ADDR);
        op        = len_addr ? link_word[31:24] : link_word[7:0];
    end

    // ------------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        addr_d  = addr_q;
        timer_d = timer_q;
        lat_d   = lat_q;
        latch_d = latch_q;
        start_d = 1'b0;
        done_d  = 1'b0;
        case (state_q)
            ST_IDLE, ST_SUSPENDED: begin
                if (frame_end && len_op && op == `OP_WRITE_ENABLE) begin
                    latch_d = 1'b1;
                end else if (frame_end && len_op && op == `OP_WRITE_DISABLE) begin
                    latch_d = 1'b0;
                end else if (frame_end && state_q == ST_SUSPENDED && len_op
                             && op == `OP_RESUME) begin
                    state_d = ST_ERASE;
                end else if (frame_end && state_q == ST_IDLE && latch_q) begin
                    // Paused state takes no new erase: array has one timer
                    kind_d = EK_NONE;
                    if (len_addr && op == `OP_SECTOR_ERASE) begin
                        kind_d = EK_SECTOR;
                        addr_d = link_word[23:0] & `ADDR_SECTOR_MASK;
                    end else if (len_addr && op == `OP_HALF_BLOCK_ERASE) begin
                        kind_d = EK_HALF_BLOCK;
                        addr_d = link_word[23:0] & `ADDR_HALF_MASK;
                    end else if (len_addr && op == `OP_BLOCK_ERASE) begin
                        kind_d = EK_BLOCK;
                        addr_d = link_word[23:0] & `ADDR_BLOCK_MASK;
                    end else if (len_op && (op == `OP_ARRAY_ERASE_A
                                            || op == `OP_ARRAY_ERASE_B)) begin
                        kind_d = EK_ARRAY;
                        addr_d = 24'h000000;
                    end
                    // Wrong length or no latch leaves the command unexecuted
                    if (kind_d != EK_NONE) begin
                        state_d = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                if (kind_q == EK_ARRAY && (BP_ANY_I || LOCK_ANY_I)) begin
                    state_d = ST_IDLE;
                end else if (kind_q != EK_ARRAY && (BP_HIT_I || LOCK_HIT_I)) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_ERASE;
                    start_d = 1'b1;
                    case (kind_q)
                        EK_SECTOR:     timer_d = 32'(SECTOR_ERASE_CYC);
                        EK_HALF_BLOCK: timer_d = 32'(HALF_BLOCK_ERASE_CYC);
                        EK_BLOCK:      timer_d = 32'(BLOCK_ERASE_CYC);
                        default:       timer_d = 32'(WHOLE_ARRAY_ERASE_CYC);
                    endcase
                end
            end
            ST_ERASE: begin
                // Only suspend is decoded here; everything else falls away
                if (frame_end && len_op && op == `OP_SUSPEND
                    && kind_q != EK_ARRAY) begin
                    state_d = ST_SUSPENDING;
                    lat_d   = 16'(SUSP_MAX - 1);
                end else if (timer_q <= 32'h00000001) begin
                    state_d = ST_IDLE;
                    latch_d = 1'b0;
                    done_d  = 1'b1;
                    timer_d = 32'h00000000;
                end else begin
                    timer_d = timer_q - 32'h00000001;
                end
            end
            ST_SUSPENDING: begin
                // Timer stays frozen while paused; erase picks up where it left
                if (lat_q == 16'h0000) begin
                    state_d = ST_SUSPENDED;
                end else begin
                    lat_d = lat_q - 16'h0001;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d = (state_d == ST_ERASE) || (state_d == ST_SUSPENDING);
        pause_d = (state_d == ST_SUSPENDING) || (state_d == ST_SUSPENDED);
    end

    // Reset stands for power loss: pause state gone, a resume finds nothing
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            state_q   <= ST_IDLE;
            kind_q    <= EK_NONE;
            addr_q    <= 24'h000000;
            timer_q   <= 32'h00000000;
            lat_q     <= 16'h0000;
            latch_q   <= `RST_FLAG;
            busy_q    <= `RST_FLAG;
            pause_q   <= `RST_FLAG;
            start_q   <= 1'b0;
            done_q    <= 1'b0;
            cs_prev_q <= `RST_CS_LEVEL;
        end else begin
            state_q   <= state_d;
            kind_q    <= kind_d;
            addr_q    <= addr_d;
            timer_q   <= timer_d;
            lat_q     <= lat_d;
            latch_q   <= latch_d;
            busy_q    <= busy_d;
            pause_q   <= pause_d;
            start_q   <= start_d;
            done_q    <= done_d;
            cs_prev_q <= cs_lvl;
        end
    end

    assign BUSY_O               = busy_q;
    assign WRITE_ENABLE_LATCH_O = latch_q;
    assign PAUSED_STATE_FLAG_O  = pause_q;
    assign ERASE_KIND_O         = kind_q;
    assign ERASE_ADDR_O         = addr_q;
    assign ERASE_START_O        = start_q;
    assign ERASE_DONE_O         = done_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_start_needs_latch;
        ERASE_START_O |-> WRITE_ENABLE_LATCH_O && BUSY_O && !PAUSED_STATE_FLAG_O;
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch)
        else $error("erase started without latch or busy");

    property p_region_protected;
        (state_q == ST_CHECK && kind_q != EK_ARRAY && (BP_HIT_I || LOCK_HIT_I))
            |=> !ERASE_START_O && state_q == ST_IDLE;
    endproperty
    a_region_protected: assert property (p_region_protected)
        else $error("protected region erase was started");

    property p_array_protected;
        (state_q == ST_CHECK && kind_q == EK_ARRAY && (BP_ANY_I || LOCK_ANY_I))
            |=> !BUSY_O && !ERASE_START_O;
    endproperty
    a_array_protected: assert property (p_array_protected)
        else $error("array erase started with protection set");

    property p_done_clears_latch;
        $fell(BUSY_O) && !PAUSED_STATE_FLAG_O |-> ERASE_DONE_O && !WRITE_ENABLE_LATCH_O;
    endproperty
    a_done_clears_latch: assert property (p_done_clears_latch)
        else $error("erase end left latch set");

    property p_suspend_flag;
        (state_q == ST_ERASE && frame_end && len_op && op == `OP_SUSPEND
         && kind_q != EK_ARRAY) |=> PAUSED_STATE_FLAG_O && BUSY_O;
    endproperty
    a_suspend_flag: assert property (p_suspend_flag)
        else $error("pause flag not set on suspend");

    property p_suspend_latency;
        $rose(PAUSED_STATE_FLAG_O) |-> BUSY_O ##[1:SUSP_MAX] !BUSY_O;
    endproperty
    a_suspend_latency: assert property (p_suspend_latency)
        else $error("busy stayed up past suspend latency");

    property p_array_no_pause;
        state_q == ST_ERASE && kind_q == EK_ARRAY |=> !PAUSED_STATE_FLAG_O;
    endproperty
    a_array_no_pause: assert property (p_array_no_pause)
        else $error("array erase was paused");

    property p_idle_no_pause;
        !BUSY_O && !PAUSED_STATE_FLAG_O |=> !PAUSED_STATE_FLAG_O;
    endproperty
    a_idle_no_pause: assert property (p_idle_no_pause)
        else $error("suspend taken while not busy");

    property p_resume_busy;
        $fell(PAUSED_STATE_FLAG_O) |-> ##[0:RES_MAX] BUSY_O;
    endproperty
    a_resume_busy: assert property (p_resume_busy)
        else $error("busy late after resume");

    property p_busy_ignores_disable;
        (state_q == ST_ERASE && frame_end && len_op && op == `OP_WRITE_DISABLE)
            |=> $stable(WRITE_ENABLE_LATCH_O) || ERASE_DONE_O;
    endproperty
    a_busy_ignores_disable: assert property (p_busy_ignores_disable)
        else $error("command taken while busy");

    c_sector_done: cover property (kind_q == EK_SECTOR && ERASE_DONE_O);
    c_suspended:   cover property (state_q == ST_SUSPENDED);
    c_resumed:     cover property ($fell(PAUSED_STATE_FLAG_O) ##[1:RES_MAX] BUSY_O);
    c_array_done:  cover property (kind_q == EK_ARRAY && ERASE_DONE_O);

endmodule : flash_erase_sequencer

`default_nettype wire

// ==== rtl/flash_erase_cfg.svh ====
/*
 * Offsets, opcodes, field positions, reset values and timing counts for the
 * serial flash erase and suspend sequencer.
 * Assumes the system clock runs at 40 MHz; included by bare name.
 */
`ifndef FLASH_ERASE_CFG_SVH
`define FLASH_ERASE_CFG_SVH

// ----------------------------------------------------------------------------
// Instruction opcodes
// ----------------------------------------------------------------------------
`define OP_WRITE_ENABLE      8'h06
`define OP_WRITE_DISABLE     8'h04
`define OP_READ_STATUS       8'h05
`define OP_SECTOR_ERASE      8'h20
`define OP_HALF_BLOCK_ERASE  8'h52
`define OP_BLOCK_ERASE       8'hD8
`define OP_ARRAY_ERASE_A     8'hC7
`define OP_ARRAY_ERASE_B     8'h60
`define OP_SUSPEND           8'h75
`define OP_RESUME            8'h7A

// ----------------------------------------------------------------------------
// Frame lengths, status byte layout, reset values
// ----------------------------------------------------------------------------
`define FRAME_BITS_OP        6'h08
`define FRAME_BITS_ADDR      6'h20
`define STAT_BUSY_BIT        0
`define STAT_LATCH_BIT       1
`define STAT_PAUSE_BIT       2
`define ADDR_SECTOR_MASK     24'hFFF000
`define ADDR_HALF_MASK       24'hFF8000
`define ADDR_BLOCK_MASK      24'hFF0000
`define RST_FLAG             1'b0
`define RST_CS_LEVEL         1'b1

// ----------------------------------------------------------------------------
// Timing: system clock period, suspend latency, resume busy latency
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS        25
`define SUSPEND_LAT_NS       20000
`define SUSPEND_LAT_CYC      (`SUSPEND_LAT_NS / `CLK_PERIOD_NS)
`define RESUME_LAT_NS        200
`define RESUME_LAT_CYC       (`RESUME_LAT_NS / `CLK_PERIOD_NS)

`endif

// ==== rtl/flash_erase_pkg.sv ====
/*
 * Types shared by the erase sequencer: erase kinds and sequencer states.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package flash_erase_pkg;

    // Kind of erase held in the target registers
    typedef enum logic [2:0] {
        EK_NONE,
        EK_SECTOR,
        EK_HALF_BLOCK,
        EK_BLOCK,
        EK_ARRAY
    } erase_kind_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_ERASE,
        ST_SUSPENDING,
        ST_SUSPENDED
    } seq_state_t;

endpackage : flash_erase_pkg

`default_nettype wire

// ==== rtl/level_sync3.sv ====
/*
 * Three-stage level synchroniser, one generate lane per bit.
 * Assumes d_i is a level from another clock domain or a pin.
 */
`timescale 1ns/10ps
`default_nettype none

module level_sync3 #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    // ------------------------------------------------------------------------
    // Filter: a change counts once stages two and three agree
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_lane
        always_comb begin
            q_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : q_q[i];
        end
    end

    // Stage one feeds only stage two, to keep metastability contained
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            q_q  <= INIT;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q  <= q_d;
        end
    end

    assign q_o = q_q;

endmodule : level_sync3

`default_nettype wire

// ==== rtl/spi_link_shifter.sv ====
/*
 * Link-side shifter on the serial clock: counts and shifts frame bits and
 * returns the status byte for a status read.
 * Assumes the serial clock runs only inside frames, mode 0, single line.
 */
`timescale 1ns/10ps
`default_nettype none
`include "flash_erase_cfg.svh"

module spi_link_shifter #(
    parameter int CNT_W = 6
) (
    input  wire logic             sclk_i,
    input  wire logic             cs_n_i,
    input  wire logic             mosi_i,
    input  wire logic [7:0]       status_i,
    output logic      [CNT_W-1:0] bits_o,
    output logic      [31:0]      word_o,
    output logic                  miso_o,
    output logic                  miso_oe_o
);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    logic             in_frame_q;
    logic             rd_q;
    logic             rd_d;
    logic [CNT_W-1:0] bits_q;
    logic [CNT_W-1:0] bits_d;
    logic [31:0]      word_q;
    logic [31:0]      word_d;
    logic [7:0]       stat_s;
    logic [7:0]       out_q;
    logic [7:0]       out_d;

    // Status bits are levels from the system domain
    level_sync3 #(.W(8), .INIT(8'h00)) u_stat_sync (
        .clk_i (sclk_i),
        .rst_i (1'b0),
        .d_i   (status_i),
        .q_o   (stat_s)
    );

    // ------------------------------------------------------------------------
    // Input shift, MSB first on rising edges while selected
    // ------------------------------------------------------------------------
    always_comb begin
        bits_d = in_frame_q ? ((bits_q == CNT_MAX) ? bits_q : bits_q + 1'b1)
                            : {{(CNT_W-1){1'b0}}, 1'b1};
        word_d = {word_q[30:0], mosi_i};
        rd_d   = in_frame_q ? rd_q : 1'b0;  // No unknown enable early in a frame
        if (bits_d == `FRAME_BITS_OP) begin
            rd_d = (word_d[7:0] == `OP_READ_STATUS);
        end
    end

    // Frame marker and read flag clear when select rises
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            in_frame_q <= 1'b0;
            rd_q       <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
            rd_q       <= rd_d;
        end
    end

    // Count and word survive the frame end, so the system side reads them
    always_ff @(posedge sclk_i) begin
        bits_q <= bits_d;
        word_q <= word_d;
    end

    // ------------------------------------------------------------------------
    // Status output: reload each byte boundary, so reads repeat the byte
    // ------------------------------------------------------------------------
    always_comb begin
        out_d = (bits_q[2:0] == 3'h0) ? stat_s : {out_q[6:0], 1'b0};
    end

    always_ff @(negedge sclk_i) begin
        out_q <= out_d;
    end

    assign bits_o    = bits_q;
    assign word_o    = word_q;
    assign miso_o    = out_q[7];
    assign miso_oe_o = rd_q & ~cs_n_i;

endmodule : spi_link_shifter

`default_nettype wire

// ==== dv/spi_host_model.sv ====
/* SPI host model: mode-0 single-line frames, MSB first, captures MISO.
   Assumes the device samples on rising SCLK and shifts out on falling. */
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // Clock stands low between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // One frame; select rises right after the last bit
    task automatic frame(input int n, input logic [39:0] d, output logic [7:0] rx);
        rx = 8'h00;
        #3.3 cs_n_o = 1'b0;  // Drifts link phase off the system clock
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = d[i];
            #62.5 sclk_o = 1'b1;
            rx = {rx[6:0], miso_i};
            #62.5 sclk_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;  // Released line must not look held
        #500;              // Gap long enough for decode
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ==== dv/serial_flash_erase_suspend_control_test.sv ====
/* Self-checking bench for the erase and suspend sequencer.
   Assumes shortened erase counts, set at the instance below. */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_erase_suspend_control_test;
    import flash_erase_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, bp_hit, lock_hit, bp_any, lock_any;
    logic        sclk, cs_n, mosi, miso, busy, latch, paused, oe, start, done;
    int          n_start = 0, n_done = 0, n_oe = 0;
    erase_kind_t kind;
    logic [23:0] addr;
    logic [7:0]  st;
    int          n_fail = 0;
    int          n_tests = 0;
    localparam logic [23:0] A = 24'h5ABCDE;
    logic [7:0]  op_t [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    logic [23:0] msk_t [5] = '{24'hFFF000, 24'hFF8000, 24'hFF0000, 24'h0, 24'h0};
    erase_kind_t knd_t [5] = '{EK_SECTOR, EK_HALF_BLOCK, EK_BLOCK, EK_ARRAY, EK_ARRAY};

    flash_erase_sequencer #(.SECTOR_ERASE_CYC(2000), .HALF_BLOCK_ERASE_CYC(2100),
        .BLOCK_ERASE_CYC(2200), .WHOLE_ARRAY_ERASE_CYC(2400)) i_flash_erase_sequencer (
        .CLOCK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi),
        .MISO_O(miso), .MISO_OE_O(oe), .BP_HIT_I(bp_hit), .LOCK_HIT_I(lock_hit),
        .BP_ANY_I(bp_any), .LOCK_ANY_I(lock_any), .BUSY_O(busy),
        .WRITE_ENABLE_LATCH_O(latch), .PAUSED_STATE_FLAG_O(paused), .ERASE_KIND_O(kind),
        .ERASE_ADDR_O(addr), .ERASE_START_O(start), .ERASE_DONE_O(done));
    spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso));

    // -------------------------------------------------------------------
    // Clock, helpers, verdict
    // -------------------------------------------------------------------
    always #12.5 clk = ~clk;
    // Pulse and drive counts, compared once at the end
    always @(posedge clk) begin
        n_start += (start === 1'b1);
        n_done  += (done === 1'b1);
    end
    always @(posedge oe) if (oe === 1'b1) n_oe++;
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cmd(input int n, input logic [39:0] d);
        i_spi_host_model.frame(n, d, st);
    endtask : cmd
    task automatic issue(input int k);
        if (k < 3) cmd(32, {op_t[k], A});
        else cmd(8, op_t[k]);
    endtask : issue
    // Bounded wait; a hang shows as busy still set
    task automatic wait_idle(input int lim);
        for (int c = 0; c < lim && busy !== 1'b0; c++) @(posedge clk);
        chk("busy clear", 0, busy);
    endtask : wait_idle
    task automatic do_reset();
        @(negedge clk) rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    task automatic give_verdict();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Watchdog, about three times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    initial begin
        {bp_hit, lock_hit, bp_any, lock_any} = 4'h0;
        do_reset();
        // Every erase kind; write disable must be ignored while busy
        for (int k = 0; k < 5; k++) begin
            cmd(8, 8'h06);
            issue(k);
            chk("kind", knd_t[k], kind);
            chk("addr", A & msk_t[k], addr);
            cmd(8, 8'h04);
            cmd(16, 16'h0500);
            chk("status", 8'h03, st);
            wait_idle(2600);
            chk("latch", 0, latch);
        end
        // Refused erases leave busy low and keep the latch
        issue(0);
        chk("no latch", 0, busy);
        cmd(8, 8'h06);
        cmd(33, {op_t[0], A, 1'b1});
        chk("bit count", 0, busy);
        @(negedge clk) bp_hit = 1'b1;
        issue(0);
        chk("bp hit", 0, busy);
        @(negedge clk) {bp_hit, lock_hit} = 2'b01;
        issue(1);
        chk("lock hit", 0, busy);
        @(negedge clk) {lock_hit, lock_any} = 2'b01;
        issue(3);
        chk("lock any", 0, busy);
        @(negedge clk) {lock_any, bp_any} = 2'b01;
        issue(4);
        chk("bp any", 0, busy);
        chk("latch kept", 1, latch);
        cmd(8, 8'h04);
        chk("latch off", 0, latch);
        cmd(8, 8'h06);
        // Pause and resume; a second suspend while paused is ignored
        @(negedge clk) bp_any = 1'b0;
        issue(0);
        cmd(8, 8'h75);
        chk("paused", 1, paused);
        wait_idle(810);
        cmd(8, 8'h75);
        cmd(16, 16'h0500);
        chk("paused status", 8'h06, st);
        cmd(8, 8'h7A);
        chk("resumed", 1, busy & ~paused);
        wait_idle(2000);
        // Whole-array erase cannot be paused; idle commands ignored
        cmd(8, 8'h06);
        issue(3);
        cmd(8, 8'h75);
        chk("array pause", 0, paused);
        wait_idle(2600);
        cmd(8, 8'h7A);
        chk("idle resume", 0, busy);
        cmd(8, 8'h75);
        chk("idle pause", 0, paused);
        // Power loss while paused
        cmd(8, 8'h06);
        issue(1);
        cmd(8, 8'h75);
        wait_idle(810);
        do_reset();
        chk("power loss", 0, paused);
        cmd(8, 8'h7A);
        chk("stale resume", 0, busy);
        chk("starts", 8, n_start);
        chk("dones", 7, n_done);
        chk("status drives", 6, n_oe);
        give_verdict();
    end
endmodule : serial_flash_erase_suspend_control_test
`default_nettype wire
